// File: hw/fiwb_ctrl.sv
// Purpose: Write buffer, address counter and control flags for flash programming.
// Assumes: Unlock pattern check and array timing are modelled by fixed counts.
// Notes:   Erase and write touch the page array held in flip-flops.
`timescale 1ns/1ps
`include "fiwb_regs.svh"
module fiwb_ctrl
  import fiwb_pkg::*;
#(
  parameter int         PAGE_BITS = 5,
  parameter int         ADDR_BITS = 13,
  parameter logic [15:0] KEY1     = 16'h1234,
  parameter logic [15:0] KEY2     = 16'h5678,
  parameter logic [15:0] KEY3     = 16'h9ABC
) (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            CHIP_RESET_REQ,
  output logic            EW_ENABLED
);
  localparam int WORDS = 1 << PAGE_BITS;
  localparam int PAGES = 1 << (ADDR_BITS - PAGE_BITS);
  localparam int PCW   = $clog2(`FIWB_PROC_CYC + 1);

  fiwb_bus_t        bus;
  logic [7:0]       ctrl0_r;
  logic [7:0]       rstpat_r;
  logic             clr_r;
  logic [ADDR_BITS-1:0] addr_r;
  logic [7:0]       d_r [8];
  logic [15:0]      wbuf_r [WORDS];
  logic [15:0]      flash_r [WORDS];
  logic [PAGE_BITS-1:0] fpage_idx;
  fiwb_state_t      st_r;
  logic [PCW-1:0]   ptmr_r;
  logic [3:0]       opcnt_r;
  logic             proc_ok;
  logic             op_done;
  logic             load_word;
  logic             at_end;
  logic [ADDR_BITS-1:0] page_base;
  fiwb_mode_t       mode;

  assign bus       = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign mode      = fiwb_mode_t'(ctrl0_r[6:4]);
  // Page number comes from the bits above the in-page offset only.
  assign page_base = {addr_r[ADDR_BITS-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
  assign fpage_idx = addr_r[PAGE_BITS-1:0];
  assign at_end    = &addr_r[PAGE_BITS-1:0];
  assign load_word = bus.wr && bus.addr == `FIWB_A_D0H && ctrl0_r[`FIWB_B_EWEN];
  assign proc_ok   = {d_r[3], d_r[2]} == KEY1 && {d_r[5], d_r[4]} == KEY2
                     && {d_r[7], d_r[6]} == KEY3;
  assign op_done   = st_r == FIWB_BUSY && opcnt_r == 4'h1;

  // Control register 0: mixed software and hardware ownership.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl0_r <= `FIWB_CTRL0_RST;
    end else begin
      if (bus.wr && bus.addr == `FIWB_A_CTRL0) begin
        ctrl0_r[6:0] <= bus.wdata[6:0];
        if (!bus.wdata[`FIWB_B_EWEN]) begin
          ctrl0_r[`FIWB_B_EWEN] <= 1'b0;
        end
      end
      if (ptmr_r == PCW'(1)) begin
        ctrl0_r[`FIWB_B_TRIG] <= 1'b0;
        if (mode == FIWB_MODE_ENABLE && proc_ok) begin
          ctrl0_r[`FIWB_B_EWEN] <= 1'b1;
        end
      end
      if (op_done) begin
        ctrl0_r[`FIWB_B_WRI] <= 1'b0;
        ctrl0_r[`FIWB_B_RDI] <= 1'b0;
      end
    end
  end

  // Enable procedure timer, restarted by each trigger write.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ptmr_r <= '0;
    end else if (bus.wr && bus.addr == `FIWB_A_CTRL0 && bus.wdata[`FIWB_B_TRIG]) begin
      ptmr_r <= PCW'(`FIWB_PROC_CYC);
    end else if (ptmr_r != '0) begin
      ptmr_r <= ptmr_r - PCW'(1);
    end
  end

  // Operation sequencer for write, erase and read.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_r    <= FIWB_IDLE;
      opcnt_r <= 4'h0;
    end else begin
      case (st_r)
        FIWB_IDLE: begin
          if (ctrl0_r[`FIWB_B_WRI] && ctrl0_r[`FIWB_B_EWEN]
              && (mode == FIWB_MODE_WRITE || mode == FIWB_MODE_ERASE)) begin
            st_r    <= FIWB_BUSY;
            opcnt_r <= (mode == FIWB_MODE_ERASE) ? 4'(`FIWB_ERASE_CYC) : 4'(`FIWB_WRITE_CYC);
          end else if (ctrl0_r[`FIWB_B_RDI] && ctrl0_r[`FIWB_B_RDEN]
                       && mode == FIWB_MODE_READ) begin
            st_r    <= FIWB_BUSY;
            opcnt_r <= 4'(`FIWB_READ_CYC);
          end
        end
        FIWB_BUSY: begin
          opcnt_r <= opcnt_r - 4'h1;
          if (opcnt_r == 4'h1) begin
            st_r <= FIWB_IDLE;
          end
        end
        default: st_r <= FIWB_IDLE;
      endcase
    end
  end

  // Buffer clear bit: one cycle clear, then hardware drops the bit.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      clr_r <= 1'b0;
    end else if (bus.wr && bus.addr == `FIWB_A_CTRL2 && bus.wdata[`FIWB_B_CLR]) begin
      clr_r <= 1'b1;
    end else begin
      clr_r <= 1'b0;
    end
  end

  // Address counter stepping the in-page offset only, stopping at the page end; no carry reaches the high byte.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      addr_r <= '0;
    end else if (bus.wr && bus.addr == `FIWB_A_ADDRL) begin
      addr_r[7:0] <= bus.wdata;
    end else if (bus.wr && bus.addr == `FIWB_A_ADDRH) begin
      addr_r[ADDR_BITS-1:8] <= bus.wdata[ADDR_BITS-9:0];
    end else if (load_word && !at_end) begin
      addr_r <= addr_r + ADDR_BITS'(1);
    end
  end

  // Data register pairs; a read fills pair 0 from the array.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        d_r[i] <= 8'h00;
      end
    end else if (op_done && mode == FIWB_MODE_READ) begin
      d_r[0] <= flash_r[fpage_idx][7:0];
      d_r[1] <= flash_r[fpage_idx][15:8];
    end else if (bus.wr && bus.addr >= `FIWB_A_D0L && bus.addr <= `FIWB_A_D3H) begin
      d_r[3'(bus.addr - `FIWB_A_D0L)] <= bus.wdata;
    end
  end

  // Write buffer and page array, one entry each per word of the page.
  generate
    for (genvar w = 0; w < WORDS; w++) begin : g_word
      always_ff @(posedge MCLK) begin
        if (!RST_N || clr_r || (op_done && mode == FIWB_MODE_WRITE)) begin
          wbuf_r[w] <= 16'h0000;
        end else if (load_word && fpage_idx == PAGE_BITS'(w)) begin
          wbuf_r[w] <= {bus.wdata, d_r[0]};
        end
      end
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          flash_r[w] <= 16'hFFFF;
        end else if (op_done && mode == FIWB_MODE_ERASE) begin
          flash_r[w] <= 16'hFFFF;
        end else if (op_done && mode == FIWB_MODE_WRITE) begin
          flash_r[w] <= flash_r[w] & wbuf_r[w];
        end
      end
    end
  endgenerate

  // Read data register and outputs.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RDATA          <= 8'h00;
      rstpat_r       <= 8'h00;
      CHIP_RESET_REQ <= 1'b0;
      EW_ENABLED     <= 1'b0;
    end else begin
      CHIP_RESET_REQ <= bus.wr && bus.addr == `FIWB_A_RSTPAT && bus.wdata == 8'h55;
      EW_ENABLED     <= ctrl0_r[`FIWB_B_EWEN];
      if (bus.wr && bus.addr == `FIWB_A_RSTPAT) begin
        rstpat_r <= bus.wdata;
      end
      if (bus.rd) begin
        case (bus.addr)
          `FIWB_A_CTRL0:  RDATA <= ctrl0_r;
          `FIWB_A_RSTPAT: RDATA <= rstpat_r;
          `FIWB_A_CTRL2:  RDATA <= {7'h00, clr_r};
          `FIWB_A_ADDRL:  RDATA <= addr_r[7:0];
          `FIWB_A_ADDRH:  RDATA <= 8'(addr_r[ADDR_BITS-1:8]);
          `FIWB_A_D0L, `FIWB_A_D0H, `FIWB_A_D1L, `FIWB_A_D1H,
          `FIWB_A_D2L, `FIWB_A_D2H, `FIWB_A_D3L, `FIWB_A_D3H:
            RDATA <= d_r[3'(bus.addr - `FIWB_A_D0L)];
          default:        RDATA <= 8'h00;
        endcase
      end else begin
        RDATA <= 8'h00;
      end
    end
  end

  // Checks.
  property p_load_inc;
    @(posedge MCLK) disable iff (!RST_N)
      load_word && !at_end && !(bus.wr && bus.addr inside {`FIWB_A_ADDRL, `FIWB_A_ADDRH})
      |=> addr_r == $past(addr_r) + ADDR_BITS'(1);
  endproperty
  a_load_inc: assert property (p_load_inc) else $error("address did not step");
  property p_stop;
    @(posedge MCLK) disable iff (!RST_N)
      load_word && at_end |=> addr_r == $past(addr_r);
  endproperty
  a_stop: assert property (p_stop) else $error("address moved past page end");
  property p_clr_drop;
    @(posedge MCLK) disable iff (!RST_N) clr_r |=> wbuf_r[0] == 16'h0000;
  endproperty
  a_clr_drop: assert property (p_clr_drop) else $error("buffer not cleared");
  // A refused load must leave the word address exactly where it was.
  property p_no_load;
    @(posedge MCLK) disable iff (!RST_N)
      !ctrl0_r[`FIWB_B_EWEN] && bus.wr && bus.addr == `FIWB_A_D0H |=> $stable(addr_r);
  endproperty
  a_no_load: assert property (p_no_load) else $error("load while disabled");
  property p_ew_one;
    @(posedge MCLK) disable iff (!RST_N)
      !ctrl0_r[`FIWB_B_EWEN] && ptmr_r != PCW'(1) |=> !ctrl0_r[`FIWB_B_EWEN];
  endproperty
  a_ew_one: assert property (p_ew_one) else $error("enabled flag set by software");
  sequence s_expire;
    ptmr_r == PCW'(1);
  endsequence
  property p_trig;
    @(posedge MCLK) disable iff (!RST_N)
      s_expire and !(bus.wr && bus.addr == `FIWB_A_CTRL0) |=> !ctrl0_r[`FIWB_B_TRIG];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not cleared");
  property p_wdone;
    @(posedge MCLK) disable iff (!RST_N)
      op_done && mode == FIWB_MODE_WRITE |=> wbuf_r[0] == 16'h0000;
  endproperty
  a_wdone: assert property (p_wdone) else $error("buffer kept after write");
  property p_rd_gate;
    @(posedge MCLK) disable iff (!RST_N)
      st_r == FIWB_IDLE && ctrl0_r[`FIWB_B_RDI] && !ctrl0_r[`FIWB_B_RDEN]
      && !ctrl0_r[`FIWB_B_WRI] |=> st_r == FIWB_IDLE;
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read ran without enable");
  property p_wr_clear;
    @(posedge MCLK) disable iff (!RST_N)
      op_done && !(bus.wr && bus.addr == `FIWB_A_CTRL0) |=> !ctrl0_r[`FIWB_B_WRI];
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write bit not cleared");

  // Loads move only the in-page offset; the page number stays put.
  property p_page_hold;
    @(posedge MCLK) disable iff (!RST_N)
      load_word |=> addr_r[ADDR_BITS-1:PAGE_BITS] == $past(page_base[ADDR_BITS-1:PAGE_BITS]);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed on load");

  // The word lands at the offset that stood before the increment.
  property p_buf_load;
    @(posedge MCLK) disable iff (!RST_N)
      load_word && !clr_r && !(op_done && mode == FIWB_MODE_WRITE)
      |=> wbuf_r[$past(fpage_idx)] == {$past(bus.wdata), $past(d_r[0])};
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("buffer word wrong");

  property p_low_only;
    @(posedge MCLK) disable iff (!RST_N)
      bus.wr && bus.addr == `FIWB_A_D0L |=> $stable(addr_r);
  endproperty
  a_low_only: assert property (p_low_only) else $error("low byte moved address");

  property p_clr_bit;
    @(posedge MCLK) disable iff (!RST_N)
      clr_r && !(bus.wr && bus.addr == `FIWB_A_CTRL2) |=> !clr_r;
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("clear bit stuck");

  // A trigger written in the expiry cycle loses to the hardware clear.
  property p_trig_start;
    @(posedge MCLK) disable iff (!RST_N)
      bus.wr && bus.addr == `FIWB_A_CTRL0 && bus.wdata[`FIWB_B_TRIG] && ptmr_r != PCW'(1)
      |=> ctrl0_r[`FIWB_B_TRIG] && ptmr_r == PCW'(`FIWB_PROC_CYC);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

  property p_ew_set;
    @(posedge MCLK) disable iff (!RST_N)
      s_expire ##0 (mode == FIWB_MODE_ENABLE && proc_ok) |=> ctrl0_r[`FIWB_B_EWEN];
  endproperty
  a_ew_set: assert property (p_ew_set) else $error("enable did not set");

  property p_ew_fail;
    @(posedge MCLK) disable iff (!RST_N)
      s_expire ##0 (!ctrl0_r[`FIWB_B_EWEN] && !proc_ok) |=> !ctrl0_r[`FIWB_B_EWEN];
  endproperty
  a_ew_fail: assert property (p_ew_fail) else $error("enable set on bad keys");

  property p_ew_clr;
    @(posedge MCLK) disable iff (!RST_N)
      bus.wr && bus.addr == `FIWB_A_CTRL0 && !bus.wdata[`FIWB_B_EWEN] && ptmr_r != PCW'(1)
      |=> !ctrl0_r[`FIWB_B_EWEN];
  endproperty
  a_ew_clr: assert property (p_ew_clr) else $error("zero did not disable");

  // The incremented address must be visible through the low register.
  property p_rd_addr;
    @(posedge MCLK) disable iff (!RST_N)
      bus.rd && bus.addr == `FIWB_A_ADDRL |=> RDATA == $past(addr_r[7:0]);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("address read wrong");

  // Operation lengths are fixed counts; a change of the counts needs these updated.
  sequence s_wr_go;
    st_r == FIWB_IDLE && ctrl0_r[`FIWB_B_WRI] && ctrl0_r[`FIWB_B_EWEN];
  endsequence
  sequence s_busy8;
    (st_r == FIWB_BUSY) [*8];
  endsequence
  sequence s_rd_go;
    st_r == FIWB_IDLE && ctrl0_r[`FIWB_B_RDI] && ctrl0_r[`FIWB_B_RDEN]
    && mode == FIWB_MODE_READ;
  endsequence

  property p_wr_len;
    @(posedge MCLK) disable iff (!RST_N)
      s_wr_go ##0 (mode == FIWB_MODE_WRITE) |=> s_busy8 ##1 (st_r == FIWB_IDLE);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write length wrong");

  property p_er_len;
    @(posedge MCLK) disable iff (!RST_N)
      s_wr_go ##0 (mode == FIWB_MODE_ERASE) |=> s_busy8 ##1 (flash_r[0] == 16'hFFFF);
  endproperty
  a_er_len: assert property (p_er_len) else $error("erase did not blank");

  property p_rd_len;
    @(posedge MCLK) disable iff (!RST_N)
      s_rd_go |=> (st_r == FIWB_BUSY) [*2] ##1 (st_r == FIWB_IDLE && !ctrl0_r[`FIWB_B_RDI]);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length wrong");

  property p_read_fill;
    @(posedge MCLK) disable iff (!RST_N)
      op_done && mode == FIWB_MODE_READ
      |=> {d_r[1], d_r[0]} == $past(flash_r[fpage_idx]);
  endproperty
  a_read_fill: assert property (p_read_fill) else $error("read word wrong");
endmodule // fiwb_ctrl

// File: hw/fiwb_pkg.sv
// Purpose: Types of the write buffer controller.
// Assumes: Nothing beyond the register header.
// Notes:   Mode codes follow the control register field.
package fiwb_pkg;
  typedef enum logic [2:0] {
    FIWB_MODE_WRITE  = 3'h0,
    FIWB_MODE_ERASE  = 3'h1,
    FIWB_MODE_READ   = 3'h3,
    FIWB_MODE_ENABLE = 3'h6
  } fiwb_mode_t;
  typedef enum logic [1:0] {
    FIWB_IDLE = 2'b00,
    FIWB_BUSY = 2'b01,
    FIWB_CLR  = 2'b11
  } fiwb_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fiwb_bus_t;
endpackage

// File: hw/fiwb_regs.svh
// Purpose: Register map, field positions and timing counts of the write buffer controller.
// Assumes: Byte registers on a plain address/strobe port; 40 MHz clock.
// Notes:   Register indices are local choices.
`ifndef FIWB_REGS_SVH
`define FIWB_REGS_SVH
`define FIWB_A_CTRL0        4'h0
`define FIWB_A_RSTPAT       4'h1
`define FIWB_A_CTRL2        4'h2
`define FIWB_A_ADDRL        4'h3
`define FIWB_A_ADDRH        4'h4
`define FIWB_A_D0L          4'h5
`define FIWB_A_D0H          4'h6
`define FIWB_A_D1L          4'h7
`define FIWB_A_D1H          4'h8
`define FIWB_A_D2L          4'h9
`define FIWB_A_D2H          4'hA
`define FIWB_A_D3L          4'hB
`define FIWB_A_D3H          4'hC
`define FIWB_B_EWEN         7
`define FIWB_B_TRIG         3
`define FIWB_B_WRI          2
`define FIWB_B_RDEN         1
`define FIWB_B_RDI          0
`define FIWB_B_CLR          0
`define FIWB_CTRL0_RST      8'h00
`define FIWB_PROC_WIN_NS    1000
`define FIWB_PROC_CYC       ((`FIWB_PROC_WIN_NS + 24) / 25)
`define FIWB_WRITE_CYC      8
`define FIWB_READ_CYC       2
`define FIWB_ERASE_CYC      8
`endif

// File: test/fiwb_core_model.sv
// Purpose: Core-side register master that plays the programming firmware.
// Assumes: One access at a time; the slave never makes the master wait.
// Notes:   Idle cycles carry inverted address and data, so stale values cannot pass.
`timescale 1ns/1ps
module fiwb_core_model
  import fiwb_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic [7:0] RDATA,
  output fiwb_bus_t       BUS
);
  initial begin
    BUS = '0;
  end
  task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge MCLK);
    BUS <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge MCLK);
    BUS <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    @(negedge MCLK);
    d = RDATA;
  endtask
endmodule // fiwb_core_model

// File: test/flash_iap_write_buffer_ctrl_tb_top.sv
// Purpose: Register-level tests of the write buffer controller.
// Assumes: Design parameters as set below; enable window of 40 cycles.
// Notes:   The unlock keys are passed to the design so expectations follow them.
`timescale 1ns/1ps
`include "fiwb_regs.svh"
module flash_iap_write_buffer_ctrl_tb_top
  import fiwb_pkg::*;
  ;
  localparam logic [15:0] K1 = 16'h1234;
  localparam logic [15:0] K2 = 16'h5678;
  localparam logic [15:0] K3 = 16'h9ABC;
  logic       mclk;
  logic       rst_n;
  fiwb_bus_t  bus;
  logic [7:0] rdata;
  logic       ew;
  logic       crq;
  int         n_fail = 0;
  int         checks = 0;
  int         cyc    = 0;
  logic [7:0] modes [4] = '{8'h00, 8'h10, 8'h30, 8'h60};
`define TB_CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
  fiwb_core_model i_core (.MCLK(mclk), .RDATA(rdata), .BUS(bus));
  fiwb_ctrl #(.PAGE_BITS(5), .ADDR_BITS(13), .KEY1(K1), .KEY2(K2), .KEY3(K3)) i_dut (
    .MCLK(mclk), .RST_N(rst_n), .ADDR(bus.addr), .WDATA(bus.wdata), .WR(bus.wr),
    .RD(bus.rd), .RDATA(rdata), .CHIP_RESET_REQ(crq), .EW_ENABLED(ew));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic final_report;
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_core.rd(a, d);
    `TB_CHK(d, e)
  endtask
  // The keys must land before the window closes, so they follow the trigger and its readback directly.
  task automatic unlock(input logic [15:0] k1);
    i_core.wr(`FIWB_A_CTRL0, 8'h68);
    rchk(`FIWB_A_CTRL0, 8'h68);
    i_core.wr(`FIWB_A_D1L, k1[7:0]);
    i_core.wr(`FIWB_A_D1H, k1[15:8]);
    i_core.wr(`FIWB_A_D2L, K2[7:0]);
    i_core.wr(`FIWB_A_D2H, K2[15:8]);
    i_core.wr(`FIWB_A_D3L, K3[7:0]);
    i_core.wr(`FIWB_A_D3H, K3[15:8]);
    repeat (45) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`FIWB_A_CTRL0, `FIWB_CTRL0_RST);
    rchk(`FIWB_A_ADDRL, 8'h00);
    rchk(4'hD, 8'h00);
    i_core.wr(`FIWB_A_RSTPAT, 8'h55);
    @(negedge mclk);
    `TB_CHK(crq, 1'b1)
    @(negedge mclk);
    `TB_CHK(crq, 1'b0)
    rchk(`FIWB_A_RSTPAT, 8'h55);
    i_core.wr(`FIWB_A_D0L, 8'h34);
    i_core.wr(`FIWB_A_D0H, 8'h12);
    rchk(`FIWB_A_ADDRL, 8'h00);
    rchk(`FIWB_A_D0H, 8'h12);
    i_core.wr(`FIWB_A_CTRL0, 8'h80);
    rchk(`FIWB_A_CTRL0, 8'h00);
    foreach (modes[i]) begin
      i_core.wr(`FIWB_A_CTRL0, modes[i]);
      rchk(`FIWB_A_CTRL0, modes[i]);
    end
    unlock(~K1);
    rchk(`FIWB_A_CTRL0, 8'h60);
    `TB_CHK(ew, 1'b0)
    unlock(K1);
    rchk(`FIWB_A_CTRL0, 8'hE0);
    `TB_CHK(ew, 1'b1)
    i_core.wr(`FIWB_A_CTRL2, 8'h01);
    rchk(`FIWB_A_CTRL2, 8'h00);
    i_core.wr(`FIWB_A_D0L, 8'hCD);
    i_core.wr(`FIWB_A_D0H, 8'hAB);
    rchk(`FIWB_A_ADDRL, 8'h01);
    rchk(`FIWB_A_ADDRH, 8'h00);
    i_core.wr(`FIWB_A_D0L, 8'h11);
    rchk(`FIWB_A_ADDRL, 8'h01);
    i_core.wr(`FIWB_A_ADDRL, 8'h1E);
    i_core.wr(`FIWB_A_D0H, 8'h22);
    i_core.wr(`FIWB_A_D0H, 8'h33);
    rchk(`FIWB_A_ADDRL, 8'h1F);
    i_core.wr(`FIWB_A_ADDRL, 8'h00);
    i_core.wr(`FIWB_A_CTRL0, 8'h84);
    rchk(`FIWB_A_CTRL0, 8'h84);
    repeat (10) @(posedge mclk);
    rchk(`FIWB_A_CTRL0, 8'h80);
    i_core.wr(`FIWB_A_CTRL0, 8'hB1);
    repeat (4) @(posedge mclk);
    rchk(`FIWB_A_D0L, 8'h11);
    i_core.wr(`FIWB_A_CTRL0, 8'h82);
    i_core.wr(`FIWB_A_CTRL0, 8'hB3);
    repeat (4) @(posedge mclk);
    rchk(`FIWB_A_CTRL0, 8'hB2);
    rchk(`FIWB_A_D0L, 8'hCD);
    rchk(`FIWB_A_D0H, 8'hAB);
    i_core.wr(`FIWB_A_CTRL0, 8'h94);
    repeat (12) @(posedge mclk);
    rchk(`FIWB_A_CTRL0, 8'h90);
    i_core.wr(`FIWB_A_CTRL0, 8'h82);
    i_core.wr(`FIWB_A_CTRL0, 8'hB3);
    repeat (4) @(posedge mclk);
    rchk(`FIWB_A_D0L, 8'hFF);
    rchk(`FIWB_A_D0H, 8'hFF);
    i_core.wr(`FIWB_A_CTRL2, 8'h01);
    i_core.wr(`FIWB_A_D0H, 8'h5A);
    rchk(`FIWB_A_ADDRL, 8'h01);
    i_core.wr(`FIWB_A_CTRL0, 8'h00);
    i_core.wr(`FIWB_A_ADDRL, 8'h05);
    i_core.wr(`FIWB_A_D0H, 8'h44);
    rchk(`FIWB_A_ADDRL, 8'h05);
    `TB_CHK(ew, 1'b0)
    final_report;
  end
endmodule // flash_iap_write_buffer_ctrl_tb_top
